// ==== shared/ttp_pkg.sv ====
// Constants, register map and carrier types of the two-note tone player.
// Assumes a single 40 MHz APB clock domain; register indices are word indices.
package ttp_pkg;

    // ****************************************
    // Bus geometry
    // ****************************************
    localparam int ADDR_W = 18;
    localparam int IDX_W = 16;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ****************************************
    // Register indices, byte address is four times the index
    // ****************************************
    localparam logic [15:0] IDX_A_PITCH_LO = 16'ha040;
    localparam logic [15:0] IDX_A_PITCH_HI = 16'ha041;
    localparam logic [15:0] IDX_A_LENGTH = 16'ha042;
    localparam logic [15:0] IDX_A_SILENCE = 16'ha043;
    localparam logic [15:0] IDX_B_PITCH_LO = 16'ha044;
    localparam logic [15:0] IDX_B_PITCH_HI = 16'ha045;
    localparam logic [15:0] IDX_B_LENGTH = 16'ha046;
    localparam logic [15:0] IDX_B_SILENCE = 16'ha047;
    localparam logic [15:0] IDX_TONE_CONTROL = 16'ha048;
    localparam logic [15:0] IDX_GATE_WINDOW = 16'ha049;
    localparam logic [15:0] IDX_TICK_GATE_IRQ = 16'ha04a;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'ha04b;
    localparam logic [15:0] IDX_IRQ_MASK = 16'ha04c;
    localparam logic [15:0] NOTE_STRIDE = 16'h0004;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTL_ENABLE_BIT = 7;
    localparam int CTL_POLARITY_BIT = 6;
    localparam int CTL_IEN_B_BIT = 5;
    localparam int CTL_IEN_A_BIT = 4;
    localparam int CTL_FLAG_B_BIT = 3;
    localparam int CTL_FLAG_A_BIT = 2;
    localparam int CTL_GO_B_BIT = 1;
    localparam int CTL_GO_A_BIT = 0;
    localparam int TU_LSB = 6;
    localparam int PRESCALE_BIT = 4;
    localparam int GATE_IEN_BIT = 1;
    localparam int GATE_FLAG_BIT = 0;
    localparam int IRQ_A_BIT = 0;
    localparam int IRQ_B_BIT = 1;
    localparam int IRQ_GATE_BIT = 2;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 40_000_000;
    localparam int UNIT_BASE_US = 1000;
    localparam int MS_CYCLES_DEF = UNIT_BASE_US * (CLK_HZ / 1_000_000);
    localparam logic [2:0] PRE_SHIFT_DIV32 = 3'd5;
    localparam logic [2:0] PRE_SHIFT_DIV64 = 3'd6;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_A_TONE = 5'b00010,
        ST_A_REST = 5'b00100,
        ST_B_TONE = 5'b01000,
        ST_B_REST = 5'b10000
    } ttp_state_t;

    typedef struct packed {
        logic [11:0] pitch;
        logic [7:0] length;
        logic [7:0] silence;
    } ttp_note_t;

    typedef struct packed {
        logic enable;
        logic polarity;
        logic ien_b;
        logic ien_a;
    } ttp_ctl_t;

endpackage

// ==== core/ttp_unit_tick.sv ====
// Time-unit tick generator of the two-note tone player.
// Assumes restart is a one-cycle pulse in the same clock domain.
`timescale 1ns/10ps
`default_nettype none
module ttp_unit_tick #(
    parameter logic [19:0] MS_CYCLES = 20'd40000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic restart,
    input wire logic [1:0] unit_sel,
    output logic tick
);
    import ttp_pkg::*;

    logic [19:0] cnt_reg;
    logic [19:0] span;

    // One unit is 1, 2, 4 or 8 ms worth of cycles
    assign span = MS_CYCLES << unit_sel;

    // Counter restarts with each phase so a unit is never short
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 20'h00000;
            tick <= 1'b0;
        end else if (restart) begin
            cnt_reg <= 20'h00000;
            tick <= 1'b0;
        end else begin
            tick <= (cnt_reg == span - 20'h00001);
            cnt_reg <= (cnt_reg == span - 20'h00001) ? 20'h00000 : cnt_reg + 20'h00001;
        end
    end
endmodule // ttp_unit_tick
`default_nettype wire

// ==== core/ttp_top.sv ====
// Two-note tone player: APB register file, note sequencer, tone divider,
// supply-gate window timer and interrupt logic.
// Assumes pclk at 40 MHz and an APB master in the same domain.
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Tone frequency is prescaled clock divided by pitch value plus one.
// - Prescale select clear divides clock by 32, set divides by 64.
// - Time unit field picks 1, 2, 4 or 8 ms per count.
// - Starting either note launches the supply-gate window for count units.
// - Window expiry sets the supply-gate flag.
// - Supply-gate flag raises interrupt only while its enable is set.
// - Note end raises interrupt when that note's end enable and its mask bit are set.
// - Note B end with enable sets its flag; writing 0 clears it.
// - Note A end with enable sets its flag; writing 0 clears it.
// - Writing 1 starts note B, 0 ignored, start clears at completion.
// - Writing 1 starts note A, 0 ignored, start clears at completion.
// - Both starts written together play note A then note B.
// - Note B busy reads 1 at the start bit while B plays.
// - Note A busy reads 1 at the start bit while A plays.
module ttp_top #(
    parameter logic [19:0] MS_CYCLES = 20'd40000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ttp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic buzzer_output,
    output logic supply_gate_active,
    output logic irq
);
    import ttp_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    ttp_note_t note_reg [2];
    ttp_ctl_t ctl_reg;
    logic [7:0] gate_count_reg;
    logic [1:0] time_unit_sel_reg;
    logic tone_prescale_sel_reg;
    logic gate_ien_reg;
    logic gate_flag_reg;
    logic flag_a_reg;
    logic flag_b_reg;
    logic go_a_reg;
    logic go_b_reg;
    logic [2:0] irq_status_reg;
    logic [2:0] irq_mask_reg;
    ttp_state_t state_reg;
    logic [7:0] rem_reg;
    logic phase_restart_reg;
    logic gate_restart_reg;
    logic gate_run_reg;
    logic [7:0] gate_rem_reg;
    logic [18:0] cyc_reg;
    logic seq_tick;
    logic gate_tick;
    logic [15:0] idx;
    logic hit;
    logic wr_en;
    logic [7:0] wbyte;
    logic [7:0] rd_next;
    logic done_a;
    logic done_b;
    logic gate_expire;
    logic go_write;
    logic in_tone;
    logic [11:0] cur_pitch;
    logic [18:0] period;
    logic [2:0] irq_events;
    logic [2:0] irq_qual;

    // ****************************************
    // APB access decode
    // ****************************************
    // Word index from the byte address; low two bits do not select
    assign idx = paddr[ADDR_W-1:2];
    assign wbyte = pwdata[7:0];
    assign wr_en = psel & penable & pwrite & pready & ~pslverr;
    assign go_write = wr_en & (idx == IDX_TONE_CONTROL) & (wbyte[CTL_GO_A_BIT] | wbyte[CTL_GO_B_BIT]);

    // Zero-wait slave: answer is prepared during the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            if (psel & ~penable & ~pwrite) begin
                prdata <= {24'h000000, rd_next};
            end
        end
    end

    // Read mux, unmapped indices read zero and flag an error
    always_comb begin
        hit = 1'b1;
        rd_next = 8'h00;
        case (idx)
            IDX_A_PITCH_LO: rd_next = note_reg[0].pitch[7:0];
            IDX_A_PITCH_HI: rd_next = {4'h0, note_reg[0].pitch[11:8]};
            IDX_A_LENGTH: rd_next = note_reg[0].length;
            IDX_A_SILENCE: rd_next = note_reg[0].silence;
            IDX_B_PITCH_LO: rd_next = note_reg[1].pitch[7:0];
            IDX_B_PITCH_HI: rd_next = {4'h0, note_reg[1].pitch[11:8]};
            IDX_B_LENGTH: rd_next = note_reg[1].length;
            IDX_B_SILENCE: rd_next = note_reg[1].silence;
            IDX_TONE_CONTROL: begin
                rd_next = {ctl_reg.enable, ctl_reg.polarity, ctl_reg.ien_b, ctl_reg.ien_a,
                           flag_b_reg, flag_a_reg,
                           state_reg == ST_B_TONE || state_reg == ST_B_REST,
                           state_reg == ST_A_TONE || state_reg == ST_A_REST};
            end
            IDX_GATE_WINDOW: rd_next = gate_count_reg;
            IDX_TICK_GATE_IRQ: begin
                rd_next = {time_unit_sel_reg, 1'b0, tone_prescale_sel_reg, 2'b00, gate_ien_reg, gate_flag_reg};
            end
            IDX_IRQ_STATUS: rd_next = {5'h00, irq_status_reg};
            IDX_IRQ_MASK: rd_next = {5'h00, irq_mask_reg};
            default: hit = 1'b0;
        endcase
    end

    // ****************************************
    // Note slot registers
    // ****************************************
    // Both slots share one layout, four indices apart
    for (genvar g = 0; g < 2; g++) begin : g_note
        localparam logic [15:0] BASE = IDX_A_PITCH_LO + NOTE_STRIDE * 16'(g);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                note_reg[g] <= '0;
            end else if (wr_en) begin
                if (idx == BASE) begin
                    note_reg[g].pitch[7:0] <= wbyte;
                end
                if (idx == BASE + 16'h0001) begin
                    note_reg[g].pitch[11:8] <= wbyte[3:0];
                end
                if (idx == BASE + 16'h0002) begin
                    note_reg[g].length <= wbyte;
                end
                if (idx == BASE + 16'h0003) begin
                    note_reg[g].silence <= wbyte;
                end
            end
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    // Plain read-write settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_reg <= '0;
            gate_count_reg <= REG_RESET;
            time_unit_sel_reg <= 2'b00;
            tone_prescale_sel_reg <= 1'b0;
            gate_ien_reg <= 1'b0;
            irq_mask_reg <= 3'h0;
        end else if (wr_en) begin
            if (idx == IDX_TONE_CONTROL) begin
                ctl_reg <= {wbyte[CTL_ENABLE_BIT], wbyte[CTL_POLARITY_BIT], wbyte[CTL_IEN_B_BIT],
                            wbyte[CTL_IEN_A_BIT]};
            end
            if (idx == IDX_GATE_WINDOW) begin
                gate_count_reg <= wbyte;
            end
            if (idx == IDX_TICK_GATE_IRQ) begin
                time_unit_sel_reg <= wbyte[TU_LSB+1:TU_LSB];
                tone_prescale_sel_reg <= wbyte[PRESCALE_BIT];
                gate_ien_reg <= wbyte[GATE_IEN_BIT];
            end
            if (idx == IDX_IRQ_MASK) begin
                irq_mask_reg <= wbyte[2:0];
            end
        end
    end

    // ****************************************
    // Start commands
    // ****************************************
    // A start clears at completion; a new start write in that cycle wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go_a_reg <= 1'b0;
            go_b_reg <= 1'b0;
        end else begin
            go_a_reg <= (go_write & wbyte[CTL_GO_A_BIT]) | (go_a_reg & ~done_a);
            go_b_reg <= (go_write & wbyte[CTL_GO_B_BIT]) | (go_b_reg & ~done_b);
        end
    end

    // ****************************************
    // Note sequencer
    // ****************************************
    assign done_a = (state_reg == ST_A_REST) && (rem_reg == 8'h00);
    assign done_b = (state_reg == ST_B_REST) && (rem_reg == 8'h00);

    // Tone for length units, silence for its units, then the note is done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            rem_reg <= 8'h00;
            phase_restart_reg <= 1'b0;
        end else begin
            phase_restart_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (go_a_reg) begin
                        state_reg <= ST_A_TONE;
                        rem_reg <= note_reg[0].length;
                        phase_restart_reg <= 1'b1;
                    end else if (go_b_reg) begin
                        state_reg <= ST_B_TONE;
                        rem_reg <= note_reg[1].length;
                        phase_restart_reg <= 1'b1;
                    end
                end
                ST_A_TONE: begin
                    if (rem_reg == 8'h00) begin
                        state_reg <= ST_A_REST;
                        rem_reg <= note_reg[0].silence;
                        phase_restart_reg <= 1'b1;
                    end else if (seq_tick && !phase_restart_reg) begin
                        rem_reg <= rem_reg - 8'h01;
                    end
                end
                ST_A_REST: begin
                    if (rem_reg == 8'h00) begin
                        // Note B queued behind A follows straight on
                        state_reg <= go_b_reg ? ST_B_TONE : ST_IDLE;
                        rem_reg <= note_reg[1].length;
                        phase_restart_reg <= go_b_reg;
                    end else if (seq_tick && !phase_restart_reg) begin
                        rem_reg <= rem_reg - 8'h01;
                    end
                end
                ST_B_TONE: begin
                    if (rem_reg == 8'h00) begin
                        state_reg <= ST_B_REST;
                        rem_reg <= note_reg[1].silence;
                        phase_restart_reg <= 1'b1;
                    end else if (seq_tick && !phase_restart_reg) begin
                        rem_reg <= rem_reg - 8'h01;
                    end
                end
                ST_B_REST: begin
                    if (rem_reg == 8'h00) begin
                        state_reg <= go_a_reg ? ST_A_TONE : ST_IDLE;
                        rem_reg <= note_reg[0].length;
                        phase_restart_reg <= go_a_reg;
                    end else if (seq_tick && !phase_restart_reg) begin
                        rem_reg <= rem_reg - 8'h01;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    rem_reg <= 8'h00;
                end
            endcase
        end
    end

    // Unit tick for the sequencer, ignored in the restart cycle
    ttp_unit_tick #(
        .MS_CYCLES(MS_CYCLES)
    ) u_seq_tick (
        .pclk(pclk),
        .presetn(presetn),
        .restart(phase_restart_reg),
        .unit_sel(time_unit_sel_reg),
        .tick(seq_tick)
    );

    // ****************************************
    // Tone divider and buzzer pin
    // ****************************************
    assign in_tone = (state_reg == ST_A_TONE) || (state_reg == ST_B_TONE);
    assign cur_pitch = (state_reg == ST_B_TONE) ? note_reg[1].pitch : note_reg[0].pitch;
    // Period in clocks: (pitch+1) times 32 or 64, widest case fits 19 bits
    assign period = ({7'h00, cur_pitch} + 19'h00001)
                    << (tone_prescale_sel_reg ? PRE_SHIFT_DIV64 : PRE_SHIFT_DIV32);

    // Cycle counter restarts at every tone phase so each note starts high, or low with polarity set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_reg <= 19'h00000;
        end else if (!in_tone || cyc_reg >= period - 19'h00001) begin
            cyc_reg <= 19'h00000;
        end else begin
            cyc_reg <= cyc_reg + 19'h00001;
        end
    end

    // Square wave gated by enable, then polarity applied to idle too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buzzer_output <= 1'b0;
        end else begin
            buzzer_output <= ctl_reg.polarity
                             ^ (ctl_reg.enable & in_tone & (cyc_reg < (period >> 1)));
        end
    end

    // ****************************************
    // Supply-gate window timer
    // ****************************************
    assign gate_expire = gate_run_reg && (gate_rem_reg == 8'h00) && !gate_restart_reg;

    // Any start write relaunches the window from its full count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_restart_reg <= 1'b0;
            gate_run_reg <= 1'b0;
            gate_rem_reg <= 8'h00;
        end else begin
            gate_restart_reg <= go_write;
            if (go_write) begin
                gate_run_reg <= 1'b1;
                gate_rem_reg <= gate_count_reg;
            end else if (gate_expire) begin
                gate_run_reg <= 1'b0;
            end else if (gate_run_reg && gate_tick && !gate_restart_reg) begin
                gate_rem_reg <= gate_rem_reg - 8'h01;
            end
        end
    end

    // Separate tick so a note phase does not disturb the window
    ttp_unit_tick #(
        .MS_CYCLES(MS_CYCLES)
    ) u_gate_tick (
        .pclk(pclk),
        .presetn(presetn),
        .restart(gate_restart_reg),
        .unit_sel(time_unit_sel_reg),
        .tick(gate_tick)
    );

    // Window pin follows the running timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_gate_active <= 1'b0;
        end else begin
            supply_gate_active <= gate_run_reg & ~gate_expire;
        end
    end

    // ****************************************
    // Flags and interrupt
    // ****************************************
    // Writing 0 clears a flag; a set in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_a_reg <= 1'b0;
            flag_b_reg <= 1'b0;
            gate_flag_reg <= 1'b0;
        end else begin
            flag_a_reg <= (done_a & ctl_reg.ien_a)
                          | (flag_a_reg & ~(wr_en && idx == IDX_TONE_CONTROL && !wbyte[CTL_FLAG_A_BIT]));
            flag_b_reg <= (done_b & ctl_reg.ien_b)
                          | (flag_b_reg & ~(wr_en && idx == IDX_TONE_CONTROL && !wbyte[CTL_FLAG_B_BIT]));
            gate_flag_reg <= gate_expire
                             | (gate_flag_reg & ~(wr_en && idx == IDX_TICK_GATE_IRQ && !wbyte[GATE_FLAG_BIT]));
        end
    end

    assign irq_events = {gate_expire, done_b, done_a};
    assign irq_qual = {gate_ien_reg, ctl_reg.ien_b, ctl_reg.ien_a};

    // Sticky status, write one to clear, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= 3'h0;
        end else if (wr_en && idx == IDX_IRQ_STATUS) begin
            irq_status_reg <= irq_events | (irq_status_reg & ~wbyte[2:0]);
        end else begin
            irq_status_reg <= irq_events | irq_status_reg;
        end
    end

    // Level line: masked status also needs the per-event enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_reg & irq_mask_reg & irq_qual);
        end
    end
endmodule // ttp_top
`default_nettype wire

// ==== bench/ttp_buzzer_model.sv ====
// Buzzer element model: measures the tone period seen on its pin.
// Assumes the pin changes only in the pclk domain.
`timescale 1ns/10ps
`default_nettype none
module ttp_buzzer_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic [15:0] period
);
    logic [15:0] cnt;
    logic last;
    // Rise to rise count; a passive load, it never drives back
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 16'h0;
            last <= 1'b0;
            period <= 16'h0;
        end else begin
            last <= pin;
            cnt <= cnt + 16'h1;
            if (pin && !last) begin
                period <= cnt + 16'h1;
                cnt <= 16'h0;
            end
        end
    end
endmodule // ttp_buzzer_model
`default_nettype wire

// ==== bench/ttp_monitor.sv ====
// Port checker of the tone player top.
// Assumes it is bound onto ttp_top; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module ttp_monitor #(
    parameter logic [19:0] MS_CYCLES = 20'd40000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ttp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic buzzer_output,
    input wire logic supply_gate_active,
    input wire logic irq
);
    import ttp_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] idx;
    logic wr_ok;
    logic [7:0] ctl_q;
    logic [7:0] gate_q;
    logic [2:0] msk_q;
    assign idx = paddr[17:2];
    assign wr_ok = psel && penable && pready && pwrite;
    // Shadows of control, window count and mask, taken at accepted writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= 8'h00;
            gate_q <= 8'h00;
            msk_q <= 3'h0;
        end else if (wr_ok) begin
            if (idx == IDX_TONE_CONTROL) ctl_q <= pwdata[7:0];
            if (idx == IDX_GATE_WINDOW) gate_q <= pwdata[7:0];
            if (idx == IDX_IRQ_MASK) msk_q <= pwdata[2:0];
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_go;
        wr_ok && idx == IDX_TONE_CONTROL && pwdata[1:0] != 2'b00 && gate_q != 8'h00;
    endsequence
    AST_PREADY_NEXT: assert property (s_setup |=> pready) else $error("pready missing after setup");
    AST_PREADY_PULSE: assert property (pready |=> !pready) else $error("pready held");
    AST_ERR_UNMAPPED: assert property (psel && !penable && (idx < IDX_A_PITCH_LO || idx > IDX_IRQ_MASK)
        |=> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
    AST_ERR_READY: assert property (pslverr |-> pready) else $error("pslverr without pready");
    AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
    AST_OFF_LEVEL: assert property ((!ctl_q[7] && $stable(ctl_q[6])) [*3]
        |-> buzzer_output == ctl_q[6]) else $error("disabled buzzer off its rest level");
    AST_IRQ_MASKED: assert property ((msk_q == 3'h0) [*3] |-> !irq) else $error("irq while masked");
    AST_GATE_START: assert property (s_go |-> ##[1:8] supply_gate_active) else $error("window idle");
endmodule // ttp_monitor
`default_nettype wire

// ==== bench/ttp_top_tb.sv ====
// Self-checking bench of the tone player top.
// Assumes package, design, monitor and buzzer model compiled before.
`timescale 1ns/10ps
`default_nettype none
module ttp_top_tb;
    import ttp_pkg::*;
    localparam logic [19:0] MS = 20'd20;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, buz, gate, irq, er;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] period;
    int n_mismatch, checks_done, seed, k, p, t, n;
    // Short unit keeps every note within a few thousand cycles
    ttp_top #(.MS_CYCLES(MS)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .buzzer_output(buz), .supply_gate_active(gate), .irq(irq));
    ttp_buzzer_model i_buz (.pclk(pclk), .presetn(presetn), .pin(buz), .period(period));
    // Clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task test_done;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task apb(input logic w, input logic [15:0] i, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_idle;
        do apb(1'b0, IDX_TONE_CONTROL, 8'h00); while (rd[1:0] !== 2'b00);
    endtask
    function automatic logic [31:0] tone_per(input int pv, input int pre);
        return (pv + 1) * (pre != 0 ? 64 : 32);
    endfunction
    function automatic int gate_cyc(input int u);
        return 2 * MS * (1 << u);
    endfunction
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        seed = 32'h88f96594;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (k = 0; k < 11; k++) begin
            apb(1'b0, IDX_A_PITCH_LO + k[15:0], 8'h00);
            chk("reset value", 32'h0, rd);
            if (k < 8) begin
                t = $random(seed);
                apb(1'b1, IDX_A_PITCH_LO + k[15:0], t[7:0]);
                apb(1'b0, IDX_A_PITCH_LO + k[15:0], 8'h00);
                chk("slot", (k % 4 == 1) ? {28'h0, t[3:0]} : {24'h0, t[7:0]}, rd);
            end
        end
        apb(1'b0, IDX_IRQ_MASK + 16'h1, 8'h00);
        chk("unmapped", 32'h1, {31'h0, er});
        apb(1'b1, IDX_A_LENGTH, 8'd60);
        apb(1'b1, IDX_A_PITCH_HI, 8'h00);
        apb(1'b1, IDX_A_SILENCE, 8'd2);
        // Pitch and prescale on note A
        for (t = 0; t < 2; t++) begin
            p = 1 + ($unsigned($random(seed)) % 8);
            apb(1'b1, IDX_A_PITCH_LO, p[7:0]);
            apb(1'b1, IDX_TICK_GATE_IRQ, t ? 8'h10 : 8'h00);
            apb(1'b1, IDX_TONE_CONTROL, 8'h91);
            apb(1'b0, IDX_TONE_CONTROL, 8'h00);
            chk("busy a", 32'h91, rd);
            wait_idle;
            chk("period", tone_per(p, t), {16'h0, period});
            chk("end a", 32'h94, rd);
            apb(1'b1, IDX_TONE_CONTROL, 8'h90);
        end
        apb(1'b1, IDX_IRQ_MASK, 8'h07);
        apb(1'b0, IDX_IRQ_STATUS, 8'h00);
        chk("irq on", 32'h1, {31'h0, irq});
        apb(1'b1, IDX_IRQ_STATUS, 8'h07);
        apb(1'b0, IDX_IRQ_STATUS, 8'h00);
        chk("irq off", 32'h0, {31'h0, irq});
        // Both starts in one write: A, then B
        apb(1'b1, IDX_B_LENGTH, 8'd30);
        apb(1'b1, IDX_TONE_CONTROL, 8'hb3);
        apb(1'b0, IDX_TONE_CONTROL, 8'h00);
        chk("a first", 32'h1, rd & 32'h3);
        do apb(1'b0, IDX_TONE_CONTROL, 8'h00); while (rd[1] !== 1'b1);
        chk("b next", 32'h2, rd & 32'h3);
        wait_idle;
        chk("end flags", 32'hbc, rd);
        // Window length for every time unit
        apb(1'b1, IDX_A_LENGTH, 8'h01);
        apb(1'b1, IDX_GATE_WINDOW, 8'h02);
        for (t = 0; t < 4; t++) begin
            apb(1'b1, IDX_TICK_GATE_IRQ, {t[1:0], 6'h02});
            apb(1'b1, IDX_IRQ_STATUS, 8'h07);
            apb(1'b1, IDX_TONE_CONTROL, 8'h41);
            n = 0;
            while (gate !== 1'b1) @(posedge pclk);
            while (gate === 1'b1) begin
                @(posedge pclk);
                n++;
            end
            chk("window", 32'h1, {31'h0, (n >= gate_cyc(t) - 6 && n <= gate_cyc(t) + 6)});
            apb(1'b0, IDX_TICK_GATE_IRQ, 8'h00);
            chk("gate flag", {24'h0, t[1:0], 6'h03}, rd);
            chk("gate irq", 32'h1, {31'h0, irq});
            apb(1'b1, IDX_TICK_GATE_IRQ, {t[1:0], 6'h00});
            wait_idle;
        end
        test_done;
    end
    // Watchdog, far beyond the expected run
    initial begin
        repeat (80000) @(posedge pclk);
        n_mismatch++;
        test_done;
    end
endmodule // ttp_top_tb
bind ttp_top ttp_monitor #(.MS_CYCLES(MS_CYCLES)) i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .buzzer_output(buzzer_output), .supply_gate_active(supply_gate_active), .irq(irq));
`default_nettype wire
